/* File: include/ufc_pkg.sv */
// constants shared by the serial frame and enable control block
// Notes on behaviour
// - parity: odd when select is 1, even when 0
// - two stop bits when selected, else one
// - break after buffered data: TX low at least 13 bits, until cleared
// - 9-bit format: ninth received bit in a read-only bit
// - 9-bit format: write-only ninth bit sent as ninth data bit
// - tx disable aborts sending, resets buffers, releases TX
// - transmitter drives TX only with both enables set
// - rx disable aborts reception, resets buffers, releases RX
// - receiver owns RX only with both enables set
// - baud speed bit: high-speed mode (1) or low-speed (0)
// - address detect: word with address bit 1 is an address
// - address detect and rx interrupt: every address word interrupts
// - address detect: word with address bit 0 dropped, no interrupt
// - wake enabled, serial clock off: RX falling edge requests wake
// - no RX wake-up while the serial clock runs
// - wake request interrupts when enabled; software restarts the clock
// - wake disabled: RX falling edge with clock off resumes nothing
// - rx interrupt enable gates all receiver interrupt requests
// - rx interrupt enabled: overrun or data available requests interrupt
// - tx idle interrupt enabled: transmitter idle requests interrupt
// - parity on: top data position carries parity
// - 8-bit timer: fH/(64(N+1)) low speed, fH/(16(N+1)) high speed
package ufc_pkg;
    // register addresses
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_BAUD = 3'h2;
    localparam logic [2:0] ADDR_DATA = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    // serial_control_a fields
    localparam int CA_GLOBAL_EN = 7;
    localparam int CA_NINE_BIT = 6;
    localparam int CA_PARITY_EN = 5;
    localparam int CA_PARITY_ODD = 4;
    localparam int CA_TWO_STOP = 3;
    localparam int CA_SEND_BREAK = 2;
    localparam int CA_RX_NINTH = 1;
    localparam int CA_TX_NINTH = 0;
    // serial_control_b fields
    localparam int CB_TX_EN = 7;
    localparam int CB_RX_EN = 6;
    localparam int CB_BAUD_HIGH = 5;
    localparam int CB_ADDR_DET = 4;
    localparam int CB_WAKE_EN = 3;
    localparam int CB_RX_IRQ_EN = 2;
    localparam int CB_TX_IDLE_IRQ_EN = 1;
    localparam int CB_TX_EMPTY_IRQ_EN = 0;
    // status fields
    localparam int ST_WAKE_REQ = 5;
    localparam int ST_OVERRUN = 4;
    localparam int ST_RX_IDLE = 3;
    localparam int ST_RX_AVAIL = 2;
    localparam int ST_TX_IDLE = 1;
    localparam int ST_TX_EMPTY = 0;
    // reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    // 16 samples per bit; low speed divides by 4 more
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [1:0] LOW_PRE_LAST = 2'h3;
    localparam logic [3:0] BREAK_BITS = 4'hD;
endpackage : ufc_pkg

/* File: logic/ufc_serial.sv */
// serial transceiver with frame options, enables, address detect and rx wake
`timescale 1ns/1ps
module ufc_serial (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // serial clock gate (fH off)
    input wire logic serial_clk_off_i,
    // serial pins
    input wire logic rx_i,
    output logic rx_ctrl_o,
    output logic tx_o,
    output logic tx_oe_o,
    // interrupt request
    output logic irq_o
);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK} ufc_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_e;

    // register state
    logic [7:0] ctrl_a, next_ctrl_a;
    logic [7:0] ctrl_b, next_ctrl_b;
    logic [7:0] baud_div, next_baud_div;
    logic [7:0] tx_hold, next_tx_hold;
    logic hold_full, next_hold_full;
    logic [7:0] rx_data, next_rx_data;
    logic rx_ninth_bit, next_rx_ninth_bit;
    logic rx_data_available, next_rx_data_available;
    logic overrun_flag, next_overrun_flag;
    logic wake_req, next_wake_req;
    logic [7:0] rdata, next_rdata;
    logic irq, next_irq;
    // baud state
    logic [7:0] pre_cnt, next_pre_cnt;
    logic [1:0] quad_cnt, next_quad_cnt;
    // transmitter state
    ufc_tx_e tx_state, next_tx_state;
    logic [8:0] tx_shift, next_tx_shift;
    logic [3:0] tx_bitn, next_tx_bitn;
    logic [3:0] tx_os, next_tx_os;
    logic tx_stop2, next_tx_stop2;
    logic [3:0] brk_cnt, next_brk_cnt;
    logic tx_line, next_tx_line;
    // receiver state
    ufc_rx_e rx_state, next_rx_state;
    logic [8:0] rx_shift, next_rx_shift;
    logic [3:0] rx_bitn, next_rx_bitn;
    logic [3:0] rx_os, next_rx_os;
    logic rx_prev, next_rx_prev;
    logic rx_done, next_rx_done;

    // decoded controls
    logic global_en;
    logic nine_bit_select;
    logic parity_enable;
    logic parity_odd_select;
    logic two_stop_select;
    logic send_break;
    logic tx_ninth_bit;
    logic transmitter_enable;
    logic receiver_enable;
    logic baud_high_speed;
    logic address_detect_enable;
    logic wake_enable;
    logic rx_irq_enable;
    logic tx_idle_irq_enable;
    logic tx_empty_irq_enable;
    logic tx_run;
    logic rx_run;
    logic tick;
    logic tx_load;
    logic tx_idle_flag;
    logic rx_idle;
    logic [3:0] nbits_last;
    logic [8:0] tx_frame;
    logic tx_parity;
    logic [8:0] rx_word;
    logic addr_bit;
    logic rx_accept;
    logic data_rd;

    assign global_en = ctrl_a[ufc_pkg::CA_GLOBAL_EN];
    assign nine_bit_select = ctrl_a[ufc_pkg::CA_NINE_BIT];
    assign parity_enable = ctrl_a[ufc_pkg::CA_PARITY_EN];
    assign parity_odd_select = ctrl_a[ufc_pkg::CA_PARITY_ODD];
    assign two_stop_select = ctrl_a[ufc_pkg::CA_TWO_STOP];
    assign send_break = ctrl_a[ufc_pkg::CA_SEND_BREAK];
    assign tx_ninth_bit = ctrl_a[ufc_pkg::CA_TX_NINTH];
    assign transmitter_enable = ctrl_b[ufc_pkg::CB_TX_EN];
    assign receiver_enable = ctrl_b[ufc_pkg::CB_RX_EN];
    assign baud_high_speed = ctrl_b[ufc_pkg::CB_BAUD_HIGH];
    assign address_detect_enable = ctrl_b[ufc_pkg::CB_ADDR_DET];
    assign wake_enable = ctrl_b[ufc_pkg::CB_WAKE_EN];
    assign rx_irq_enable = ctrl_b[ufc_pkg::CB_RX_IRQ_EN];
    assign tx_idle_irq_enable = ctrl_b[ufc_pkg::CB_TX_IDLE_IRQ_EN];
    assign tx_empty_irq_enable = ctrl_b[ufc_pkg::CB_TX_EMPTY_IRQ_EN];

    assign tx_run = global_en & transmitter_enable;
    assign rx_run = global_en & receiver_enable;
    assign tx_idle_flag = ~hold_full & (tx_state == TX_IDLE);
    assign rx_idle = (rx_state == RX_IDLE);
    assign nbits_last = nine_bit_select ? 4'h8 : 4'h7;
    assign data_rd = rd_i & (addr_i == ufc_pkg::ADDR_DATA);

    // parity replaces the top data position
    assign tx_parity = (nine_bit_select ? ^tx_hold : ^tx_hold[6:0]) ^ parity_odd_select;
    always_comb begin
        tx_frame = {tx_ninth_bit & nine_bit_select, tx_hold};
        if (parity_enable) begin
            if (nine_bit_select) begin
                tx_frame[8] = tx_parity;
            end else begin
                tx_frame[7] = tx_parity;
            end
        end
    end

    // bits enter from the top; 8-bit words sit one place high
    assign rx_word = nine_bit_select ? rx_shift : {1'b0, rx_shift[8:1]};
    assign addr_bit = nine_bit_select ? rx_word[8] : rx_word[7];
    assign rx_accept = ~address_detect_enable | addr_bit;

    // baud generator; a stopped serial clock freezes the engine
    assign tick = global_en & ~serial_clk_off_i & (pre_cnt == baud_div)
                  & (baud_high_speed | (quad_cnt == ufc_pkg::LOW_PRE_LAST));
    always_comb begin
        next_pre_cnt = pre_cnt;
        next_quad_cnt = quad_cnt;
        if (!global_en) begin
            next_pre_cnt = 8'h00;
            next_quad_cnt = 2'h0;
        end else if (!serial_clk_off_i) begin
            if (pre_cnt == baud_div) begin
                next_pre_cnt = 8'h00;
                next_quad_cnt = baud_high_speed ? 2'h0 : quad_cnt + 2'h1;
            end else begin
                next_pre_cnt = pre_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_cnt <= 8'h00;
            quad_cnt <= 2'h0;
        end else begin
            pre_cnt <= next_pre_cnt;
            quad_cnt <= next_quad_cnt;
        end
    end

    // transmitter
    always_comb begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_bitn = tx_bitn;
        next_tx_os = tx_os;
        next_tx_stop2 = tx_stop2;
        next_brk_cnt = brk_cnt;
        next_tx_line = tx_line;
        tx_load = 1'b0;
        if (!tx_run) begin
            next_tx_state = TX_IDLE;
            next_tx_line = 1'b1;
            next_tx_os = 4'h0;
        end else begin
            unique case (tx_state)
                TX_IDLE: begin
                    // queued data goes out before any break
                    if (hold_full) begin
                        tx_load = 1'b1;
                        next_tx_shift = tx_frame;
                        next_tx_state = TX_START;
                        next_tx_os = 4'h0;
                        next_tx_line = 1'b0;
                    end else if (send_break) begin
                        next_tx_state = TX_BREAK;
                        next_brk_cnt = 4'h0;
                        next_tx_os = 4'h0;
                        next_tx_line = 1'b0;
                    end
                end
                TX_START: begin
                    if (tick) begin
                        next_tx_os = tx_os + 4'h1;
                        if (tx_os == ufc_pkg::OS_LAST) begin
                            next_tx_state = TX_DATA;
                            next_tx_bitn = nbits_last;
                            next_tx_line = tx_shift[0];
                        end
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        next_tx_os = tx_os + 4'h1;
                        if (tx_os == ufc_pkg::OS_LAST) begin
                            if (tx_bitn == 4'h0) begin
                                next_tx_state = TX_STOP;
                                next_tx_stop2 = two_stop_select;
                                next_tx_line = 1'b1;
                            end else begin
                                next_tx_shift = {1'b0, tx_shift[8:1]};
                                next_tx_bitn = tx_bitn - 4'h1;
                                next_tx_line = tx_shift[1];
                            end
                        end
                    end
                end
                TX_STOP: begin
                    if (tick) begin
                        next_tx_os = tx_os + 4'h1;
                        if (tx_os == ufc_pkg::OS_LAST) begin
                            if (tx_stop2) begin
                                next_tx_stop2 = 1'b0;
                            end else begin
                                next_tx_state = TX_IDLE;
                            end
                        end
                    end
                end
                TX_BREAK: begin
                    if (tick) begin
                        next_tx_os = tx_os + 4'h1;
                        if (tx_os == ufc_pkg::OS_LAST && brk_cnt != ufc_pkg::BREAK_BITS) begin
                            next_brk_cnt = brk_cnt + 4'h1;
                        end
                    end
                    if (brk_cnt == ufc_pkg::BREAK_BITS && !send_break) begin
                        next_tx_state = TX_IDLE;
                        next_tx_line = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_state <= TX_IDLE;
            tx_shift <= 9'h000;
            tx_bitn <= 4'h0;
            tx_os <= 4'h0;
            tx_stop2 <= 1'b0;
            brk_cnt <= 4'h0;
            tx_line <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_bitn <= next_tx_bitn;
            tx_os <= next_tx_os;
            tx_stop2 <= next_tx_stop2;
            brk_cnt <= next_brk_cnt;
            tx_line <= next_tx_line;
        end
    end

    // receiver; rx_i taken as synchronous
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_bitn = rx_bitn;
        next_rx_os = rx_os;
        next_rx_done = 1'b0;
        next_rx_prev = rx_i;
        if (!rx_run) begin
            next_rx_state = RX_IDLE;
            next_rx_os = 4'h0;
        end else if (tick) begin
            next_rx_os = rx_os + 4'h1;
            unique case (rx_state)
                RX_IDLE: begin
                    next_rx_os = 4'h0;
                    if (!rx_i) begin
                        next_rx_state = RX_START;
                    end
                end
                RX_START: begin
                    // a glitch under half a bit is no start
                    if (rx_os == ufc_pkg::OS_MID) begin
                        next_rx_os = 4'h0;
                        next_rx_bitn = nbits_last;
                        next_rx_state = rx_i ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_os == ufc_pkg::OS_LAST) begin
                        next_rx_shift = {rx_i, rx_shift[8:1]};
                        if (rx_bitn == 4'h0) begin
                            next_rx_state = RX_STOP;
                        end else begin
                            next_rx_bitn = rx_bitn - 4'h1;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_os == ufc_pkg::OS_LAST) begin
                        next_rx_state = RX_IDLE;
                        next_rx_done = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_state <= RX_IDLE;
            rx_shift <= 9'h000;
            rx_bitn <= 4'h0;
            rx_os <= 4'h0;
            rx_prev <= 1'b1;
            rx_done <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_bitn <= next_rx_bitn;
            rx_os <= next_rx_os;
            rx_prev <= next_rx_prev;
            rx_done <= next_rx_done;
        end
    end

    // registers, flags and interrupt request
    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_baud_div = baud_div;
        next_tx_hold = tx_hold;
        next_hold_full = hold_full;
        next_rx_data = rx_data;
        next_rx_ninth_bit = rx_ninth_bit;
        next_rx_data_available = rx_data_available;
        next_overrun_flag = overrun_flag;
        next_wake_req = wake_req;
        next_rdata = 8'h00;
        if (tx_load) begin
            next_hold_full = 1'b0;
        end
        if (data_rd) begin
            next_rx_data_available = 1'b0;
            next_overrun_flag = 1'b0;
        end
        if (wr_i) begin
            unique case (addr_i)
                ufc_pkg::ADDR_CTRL_A: next_ctrl_a = wdata_i;
                ufc_pkg::ADDR_CTRL_B: next_ctrl_b = wdata_i;
                ufc_pkg::ADDR_BAUD: next_baud_div = wdata_i;
                ufc_pkg::ADDR_DATA: begin
                    next_tx_hold = wdata_i;
                    next_hold_full = 1'b1;
                end
                default: ;
            endcase
        end
        // a word arriving with a read of the data register still lands
        if (rx_done && rx_accept) begin
            if (rx_data_available && !data_rd) begin
                next_overrun_flag = 1'b1;
            end else begin
                next_rx_data = rx_word[7:0];
                next_rx_ninth_bit = rx_word[8];
                next_rx_data_available = 1'b1;
            end
        end
        if (!next_ctrl_b[ufc_pkg::CB_TX_EN]) begin
            next_hold_full = 1'b0;
        end
        if (!next_ctrl_b[ufc_pkg::CB_RX_EN]) begin
            next_rx_data_available = 1'b0;
            next_overrun_flag = 1'b0;
        end
        if (!next_ctrl_a[ufc_pkg::CA_GLOBAL_EN]) begin
            next_ctrl_b[ufc_pkg::CB_TX_EN] = 1'b0;
            next_ctrl_b[ufc_pkg::CB_RX_EN] = 1'b0;
            next_ctrl_a[ufc_pkg::CA_SEND_BREAK] = 1'b0;
            next_hold_full = 1'b0;
            next_rx_data_available = 1'b0;
            next_overrun_flag = 1'b0;
        end
        // wake request lives only while the serial clock is off
        if (!serial_clk_off_i) begin
            next_wake_req = 1'b0;
        end
        if (serial_clk_off_i && wake_enable && rx_prev && !rx_i) begin
            next_wake_req = 1'b1;
        end
        if (rd_i) begin
            unique case (addr_i)
                ufc_pkg::ADDR_CTRL_A: begin
                    next_rdata = ctrl_a;
                    next_rdata[ufc_pkg::CA_RX_NINTH] = rx_ninth_bit;
                    next_rdata[ufc_pkg::CA_TX_NINTH] = 1'b0;
                end
                ufc_pkg::ADDR_CTRL_B: next_rdata = ctrl_b;
                ufc_pkg::ADDR_BAUD: next_rdata = baud_div;
                ufc_pkg::ADDR_DATA: next_rdata = rx_data;
                ufc_pkg::ADDR_STATUS: begin
                    next_rdata[ufc_pkg::ST_WAKE_REQ] = wake_req;
                    next_rdata[ufc_pkg::ST_OVERRUN] = overrun_flag;
                    next_rdata[ufc_pkg::ST_RX_IDLE] = rx_idle;
                    next_rdata[ufc_pkg::ST_RX_AVAIL] = rx_data_available;
                    next_rdata[ufc_pkg::ST_TX_IDLE] = tx_idle_flag;
                    next_rdata[ufc_pkg::ST_TX_EMPTY] = ~hold_full;
                end
                default: ;
            endcase
        end
        next_irq = (rx_irq_enable & (rx_data_available | overrun_flag | wake_req))
                   | (tx_idle_irq_enable & tx_idle_flag)
                   | (tx_empty_irq_enable & ~hold_full);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_a <= ufc_pkg::CTRL_A_RST;
            ctrl_b <= ufc_pkg::CTRL_B_RST;
            baud_div <= ufc_pkg::BAUD_RST;
            tx_hold <= 8'h00;
            hold_full <= 1'b0;
            rx_data <= 8'h00;
            rx_ninth_bit <= 1'b0;
            rx_data_available <= 1'b0;
            overrun_flag <= 1'b0;
            wake_req <= 1'b0;
            rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            baud_div <= next_baud_div;
            tx_hold <= next_tx_hold;
            hold_full <= next_hold_full;
            rx_data <= next_rx_data;
            rx_ninth_bit <= next_rx_ninth_bit;
            rx_data_available <= next_rx_data_available;
            overrun_flag <= next_overrun_flag;
            wake_req <= next_wake_req;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    assign rdata_o = rdata;
    assign tx_o = tx_line | ~tx_run;
    assign tx_oe_o = tx_run;
    assign rx_ctrl_o = rx_run;
    assign irq_o = irq;
endmodule : ufc_serial

/* File: tb/ufc_peer.sv */
// behavioural far-end serial peer on the tx and rx lines
`timescale 1ns/1ps
module ufc_peer (
    // clock
    input wire logic clk_i,
    // serial lines
    input wire logic tx_i,
    input wire logic tx_oe_i,
    output logic rx_o = 1'b1
);
    // released tx pulled up
    wire line = tx_oe_i ? tx_i : 1'b1;
    task automatic send(input logic [10:0] b, input int n, input int bt);
        rx_o <= 1'b0;
        repeat (bt) @(posedge clk_i);
        for (int i = 0; i <= n; i++) begin
            rx_o <= (i == n) | b[i];
            repeat (bt) @(posedge clk_i);
        end
    endtask : send
    // mid-bit sampling absorbs prescaler phase
    task automatic recv(output logic [10:0] w, input int n, input int bt, output logic ok);
        w = '1;
        ok = 1'b0;
        for (int k = 0; k < 4000 && !ok; k++) begin
            @(posedge clk_i);
            ok = (line === 1'b0);
        end
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (bt) @(posedge clk_i);
            w[i] = line;
        end
    endtask : recv
endmodule : ufc_peer

/* File: tb/ufc_serial_monitor.sv */
// assertion checker bound to the serial control ports
`timescale 1ns/1ps
module ufc_serial_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // serial side
    input wire logic serial_clk_off_i,
    input wire logic rx_ctrl_o,
    input wire logic tx_o,
    input wire logic tx_oe_o,
    input wire logic irq_o
);
    logic [7:0] ca, cb, next_ca, next_cb;
    logic [9:0] low, next_low;
    always_comb begin
        next_ca = (wr_i && addr_i == ufc_pkg::ADDR_CTRL_A) ? wdata_i : ca;
        next_cb = (wr_i && addr_i == ufc_pkg::ADDR_CTRL_B) ? wdata_i : cb;
        // global off clears both direction enables
        if (!next_ca[7]) next_cb[7:6] = 2'h0;
        next_low = (!tx_o && tx_oe_o) ? low + 10'h001 : 10'h000;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) {ca, cb, low} <= '0;
        else {ca, cb, low} <= {next_ca, next_cb, next_low};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    tx_drive_a: assert property (tx_oe_o == (ca[7] && cb[7]))
        else $error("tx drive");
    rx_own_a: assert property (rx_ctrl_o == (ca[7] && cb[6]))
        else $error("rx owner");
    tx_off_a: assert property (wr_i && addr_i == ufc_pkg::ADDR_CTRL_B && !wdata_i[7] |=>
        !tx_oe_o && tx_o) else $error("tx not released");
    rx_off_a: assert property (wr_i && addr_i == ufc_pkg::ADDR_CTRL_B && !wdata_i[6] |=>
        !rx_ctrl_o) else $error("rx not released");
    irq_gate_a: assert property (cb[2:0] == 3'h0 && $past(cb[2:0]) == 3'h0 |-> !irq_o)
        else $error("irq gated");
    ninth_wo_a: assert property (rd_i && addr_i == ufc_pkg::ADDR_CTRL_A |=> !rdata_o[0])
        else $error("ninth read");
    wake_on_a: assert property (rd_i && addr_i == ufc_pkg::ADDR_STATUS && !serial_clk_off_i
        && !$past(serial_clk_off_i) && !$past(serial_clk_off_i, 2) |=> !rdata_o[5])
        else $error("wake on");
    // high speed, divisor 0: 16-cycle bits, break >= 13 bits
    low_run_a: assert property ($rose(tx_o) && tx_oe_o && $past(tx_oe_o) && cb[5] |->
        (low <= 10'd160 && low[3:0] == 4'h0) || low >= 10'd208) else $error("bad low run");
    cover property ($rose(irq_o));
    cover property (low >= 10'd208);
    cover property ($fell(tx_oe_o) && !$past(tx_o));
endmodule : ufc_serial_monitor
bind ufc_serial ufc_serial_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_o(tx_o),
    .serial_clk_off_i(serial_clk_off_i), .rx_ctrl_o(rx_ctrl_o), .tx_oe_o(tx_oe_o), .irq_o(irq_o));

/* File: tb/ufc_serial_tb.sv */
// self-checking bench for the serial control block
`timescale 1ns/1ps
module ufc_serial_tb;
    logic clk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, off = 1'b0, rx, rxc, tx, oe, irq;
    logic ok;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00, rdata, d;
    logic [10:0] w, e;
    int miscompares = 0, num_checks = 0, n;
    ufc_serial uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .serial_clk_off_i(off), .rx_i(rx), .rx_ctrl_o(rxc),
        .tx_o(tx), .tx_oe_o(oe), .irq_o(irq));
    ufc_peer peer (.clk_i(clk_i), .tx_i(tx), .tx_oe_i(oe), .rx_o(rx));
    initial forever #4 clk_i = ~clk_i;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic fail_out();
        miscompares++;
        end_of_test();
    endtask : fail_out
    task automatic chk(input string nm, input logic [10:0] s, input logic [10:0] x);
        num_checks++;
        if (s !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // one strobe cycle; read data taken next cycle
    task automatic bus(input logic wrt, input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        wd <= v;
        wr <= wrt;
        rd <= !wrt;
        @(posedge clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 d = rdata;
    endtask : bus
    task automatic irq_within(input int lim, input logic x);
        ok = 1'b0;
        for (int k = 0; k < lim && !ok; k++) begin
            @(posedge clk_i);
            #1 ok = (irq === 1'b1);
        end
        if (x && !ok) fail_out();
    endtask : irq_within
    task automatic t_regs();
        bus(1'b0, 3'h1, 8'h00);
        chk("ctrl_b", d, 8'h00);
        bus(1'b1, 3'h0, 8'h03);
        bus(1'b0, 3'h0, 8'h00);
        chk("ninth", d, 8'h00);
        bus(1'b1, 3'h6, 8'hFF);
        bus(1'b0, 3'h6, 8'h00);
        chk("unmapped", d, 8'h00);
        $display("regs done");
    endtask : t_regs
    task automatic t_frames();
        logic [7:0] cfg [6] = '{8'h00, 8'h30, 8'h28, 8'h41, 8'h48, 8'h70};
        logic [7:0] dv;
        for (int i = 0; i < 6; i++) begin
            dv = 8'h35 + 8'h1F * i[7:0];
            bus(1'b1, 3'h0, 8'h80 | cfg[i]);
            bus(1'b1, 3'h1, (i > 0) ? 8'hA0 : 8'h80);
            bus(1'b1, 3'h3, dv);
            e = {2'h3, cfg[i][0], dv};
            if (cfg[i][6:5] == 2'h3) e[8] = ^dv ^ cfg[i][4];
            if (cfg[i][6:5] == 2'h1) e[7] = ^dv[6:0] ^ cfg[i][4];
            if (!cfg[i][6]) e[8] = 1'b1;
            peer.recv(w, 9 + cfg[i][6] + cfg[i][3], (i > 0) ? 16 : 64, ok);
            chk("frame", w, e);
            if (!ok) fail_out();
            repeat (64) @(posedge clk_i);
        end
        $display("frames done");
    endtask : t_frames
    task automatic t_rx();
        bus(1'b1, 3'h1, 8'h74);
        bus(1'b1, 3'h0, 8'hC0);
        peer.send(11'h03C, 9, 16);
        irq_within(200, 1'b0);
        chk("data irq", ok, 1'b0);
        peer.send(11'h1A7, 9, 16);
        irq_within(200, 1'b1);
        chk("addr irq", ok, 1'b1);
        bus(1'b0, 3'h0, 8'h00);
        chk("rx ninth", d[1], 1'b1);
        bus(1'b0, 3'h3, 8'h00);
        chk("addr word", d, 8'hA7);
        bus(1'b1, 3'h1, 8'h00);
        chk("rx released", rxc, 1'b0);
        $display("rx done");
    endtask : t_rx
    task automatic t_break();
        bus(1'b1, 3'h1, 8'hA0);
        bus(1'b1, 3'h0, 8'h80);
        bus(1'b1, 3'h3, 8'hFF);
        bus(1'b1, 3'h0, 8'h84);
        peer.recv(w, 9, 16, ok);
        chk("pre-break", w, 11'h7FF);
        if (!ok) fail_out();
        n = 0;
        for (int k = 0; k < 400 && n < 100; k++) begin
            @(posedge clk_i);
            #1 n += (tx === 1'b0);
        end
        bus(1'b1, 3'h0, 8'h80);
        for (int k = 0; k < 400 && tx !== 1'b1; k++) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk("brk end", tx, 1'b1);
        chk("brk len", n >= 206, 1'b1);
        bus(1'b1, 3'h3, 8'h00);
        repeat (40) @(posedge clk_i);
        bus(1'b1, 3'h1, 8'h20);
        chk("abort", {oe, tx}, 2'h1);
        $display("break done");
    endtask : t_break
    task automatic t_wake();
        bus(1'b1, 3'h0, 8'h80);
        // off+wake, off+no wake, on+wake
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 3'h1, (i == 1) ? 8'h04 : 8'h0C);
            off <= (i < 2);
            peer.send(11'h000, 0, 4);
            irq_within(20, i == 0);
            chk("wake irq", ok, i == 0);
            off <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        bus(1'b0, 3'h4, 8'h00);
        chk("wake clr", d[5], 1'b0);
        $display("wake done");
    endtask : t_wake
    initial begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_frames();
        t_rx();
        t_break();
        t_wake();
        end_of_test();
    end
endmodule : ufc_serial_tb
